/* inc/swp_pkg.sv */
package swp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command codes seen on the serial link
    localparam logic [7:0] CMD_LATCH_SET   = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] CMD_STATUS_WR   = 8'h01;
    localparam logic [7:0] CMD_STATUS_RDLO = 8'h05;
    localparam logic [7:0] CMD_STATUS_RDHI = 8'h35;
    localparam logic [7:0] CMD_PROGRAM     = 8'h02;
    localparam logic [7:0] CMD_PROGRAM_Q   = 8'h32;
    localparam logic [7:0] CMD_SECTOR_ERS  = 8'h20;
    localparam logic [7:0] CMD_BLK32_ERS   = 8'h52;
    localparam logic [7:0] CMD_BLK64_ERS   = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERS_A  = 8'hC7;
    localparam logic [7:0] CMD_CHIP_ERS_B  = 8'h60;
    localparam logic [7:0] CMD_SLEEP       = 8'hB9;
    localparam logic [7:0] CMD_WAKE        = 8'hAB;

    ////////////////////////////////////////////////////////////////////////
    // Whole bytes a frame must carry, the byte count ceiling and the last bit of a byte
    localparam logic [2:0] LEN_ONE     = 3'h1;
    localparam logic [2:0] LEN_SR_ONE  = 3'h2;
    localparam logic [2:0] LEN_SR_TWO  = 3'h3;
    localparam logic [2:0] LEN_ADDR    = 3'h4;
    localparam logic [2:0] LEN_PROG    = 3'h5;
    localparam logic [2:0] LEN_SAT     = 3'h7;
    localparam logic [2:0] BIT_LAST    = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Array geometry, 2M bytes
    localparam int         ARRAY_AW     = 21;
    localparam logic [20:0] ARRAY_LAST  = 21'h1FFFFF;
    localparam logic [20:0] SPAN_PAGE   = 21'h0000FF;
    localparam logic [20:0] SPAN_SECTOR = 21'h000FFF;
    localparam logic [20:0] SPAN_BLK32  = 21'h007FFF;
    localparam logic [20:0] SPAN_BLK64  = 21'h00FFFF;
    localparam logic [20:0] UNIT_BLOCK  = 21'h010000;
    localparam logic [20:0] UNIT_SECTOR = 21'h001000;
    localparam logic [20:0] SECTOR_MAX  = 21'h008000;

    ////////////////////////////////////////////////////////////////////////
    // Status word bit positions
    localparam int SB_BUSY   = 0;
    localparam int SB_LATCH  = 1;
    localparam int SB_BP_LO  = 2;
    localparam int SB_BP_HI  = 6;
    localparam int SB_SRP_LO = 7;
    localparam int SB_SRP_HI = 8;
    localparam int SB_QE     = 9;
    localparam int SB_SUS_P  = 10;
    localparam int SB_LB_LO  = 11;
    localparam int SB_LB_HI  = 13;
    localparam int SB_CMP    = 14;
    localparam int SB_SUS_E  = 15;
    localparam int HI_OFS    = 8;

    // Core activity, Gray along idle-busy-idle and idle-sleep-idle
    typedef enum logic [1:0] {
        SWP_IDLE  = 2'b00,
        SWP_BUSY  = 2'b01,
        SWP_SLEEP = 2'b10
    } swp_mode_e;

    // Kind of array operation handed downstream
    typedef enum logic [1:0] {
        SWP_OP_PROGRAM = 2'b00,
        SWP_OP_SECTOR  = 2'b01,
        SWP_OP_BLOCK   = 2'b10,
        SWP_OP_CHIP    = 2'b11
    } swp_op_e;

endpackage

/* rtl/swp_core.sv */
module swp_core #(
    parameter int OP_BUSY_CYCLES = 64
) (
    // Core clock and power-up reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // Serial link
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        si_i,
    input  wire logic        wp_n_i,
    output logic             so_o,
    output logic             so_oe_n_o,
    // Status and array operation request
    output logic [15:0]      status_word_o,
    output logic             array_op_valid_o,
    output swp_pkg::swp_op_e array_op_kind_o,
    output logic [23:0]      array_op_addr_o
);

    localparam int BUSY_W = $clog2(OP_BUSY_CYCLES + 1);

    generate
        if (OP_BUSY_CYCLES < 1) begin : g_bad_busy
            $error("OP_BUSY_CYCLES must be at least one");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Range decode shared by the start and end checks

    // Address falls inside the protected area
    function automatic logic prot_hit(
        input logic [4:0]  bp,
        input logic        inv,
        input logic [20:0] a
    );
        logic [2:0]  code;
        logic [20:0] size;
        logic        in_rng;
        code   = bp[2:0];
        size   = swp_pkg::UNIT_BLOCK << (code - 3'h1);
        in_rng = 1'b0;
        if (bp[4]) begin
            size = code[2] ? swp_pkg::SECTOR_MAX
                 : swp_pkg::UNIT_SECTOR << (code[1:0] - 2'h1);
        end
        // Bit 3 picks bottom, otherwise top of array
        if (bp[3]) begin
            in_rng = (a < size);
        end else begin
            in_rng = (a > (swp_pkg::ARRAY_LAST - size));
        end
        if (code == 3'h0) begin
            in_rng = 1'b0;
        end
        if (bp[2] && bp[1]) begin
            in_rng = 1'b1;
        end
        return in_rng ^ inv;
    endfunction

    // Some part of the array is protected
    function automatic logic prot_any(
        input logic [4:0] bp,
        input logic       inv
    );
        return inv ? !(bp[2] && bp[1]) : (bp[2:0] != 3'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain: frame position, cleared by the frame's own select

    typedef struct packed {
        logic       fresh;
        logic [2:0] bit_idx;
    } swp_frame_s;

    // Captured bytes, kept after the frame for the core to read
    typedef struct packed {
        logic [6:0]  sh;
        logic [2:0]  byte_cnt;
        logic        aligned;
        logic        tog;
        logic [7:0]  cmd;
        logic [23:0] addr;
        logic [7:0]  sr_lo;
        logic [7:0]  sr_hi;
        logic [15:0] word_m;
        logic [15:0] word_s;
        logic        sleep_m;
        logic        sleep_s;
    } swp_capt_s;

    // Read-back driver on the falling edge
    typedef struct packed {
        logic so;
        logic oe_n;
    } swp_out_s;

    // Core domain
    typedef struct packed {
        logic                cs_m;
        logic                cs_s;
        logic                cs_d;
        logic                wp_m;
        logic                wp_s;
        logic                seen_tog;
        swp_pkg::swp_mode_e  mode;
        logic [BUSY_W-1:0]   busy_cnt;
        logic                latch;
        logic [4:0]          bp;
        logic                cmp;
        logic                srp_hi;
        logic                srp_lo;
        logic                qe;
        logic [2:0]          lb;
        logic                op_valid;
        swp_pkg::swp_op_e    op_kind;
        logic [23:0]         op_addr;
        logic [15:0]         word;
    } swp_core_s;

    swp_frame_s fr, next_fr;
    swp_capt_s  cp, next_cp;
    swp_out_s   ot, next_ot;
    swp_core_s  r,  next_r;

    logic       frame_rst_n;
    logic [7:0] rx_byte;
    logic [2:0] cur_cnt;
    logic [7:0] rd_byte;

    // Select high ends the frame without needing a clock edge
    assign frame_rst_n = nrst_i & ~cs_n_i;

    ////////////////////////////////////////////////////////////////////////
    // Link side shifting and capture
    always_comb begin
        next_fr         = fr;
        next_cp         = cp;
        rx_byte         = {cp.sh, si_i};
        cur_cnt         = fr.fresh ? 3'h0 : cp.byte_cnt;
        next_fr.fresh   = 1'b0;
        next_fr.bit_idx = fr.bit_idx + 3'h1;
        next_cp.sh      = {cp.sh[5:0], si_i};
        next_cp.byte_cnt = cur_cnt;
        // Lets the core tell a clockless frame from a real one
        if (fr.fresh) begin
            next_cp.tog = ~cp.tog;
        end
        // Byte boundary tracked on every edge
        // boundary check
        next_cp.aligned = (fr.bit_idx == swp_pkg::BIT_LAST);
        if (fr.bit_idx == swp_pkg::BIT_LAST) begin
            case (cur_cnt)
                3'h0: begin
                    next_cp.cmd = rx_byte;
                end
                3'h1: begin
                    next_cp.addr[23:16] = rx_byte;
                    next_cp.sr_lo       = rx_byte;
                end
                3'h2: begin
                    next_cp.addr[15:8] = rx_byte;
                    next_cp.sr_hi      = rx_byte;
                end
                3'h3: begin
                    next_cp.addr[7:0] = rx_byte;
                end
                default: begin
                    next_cp.addr = cp.addr;
                end
            endcase
            if (cur_cnt != swp_pkg::LEN_SAT) begin
                next_cp.byte_cnt = cur_cnt + 3'h1;
            end
        end
        // Status copy is a set of slow levels, settled by the data phase
        next_cp.word_m  = r.word;
        next_cp.word_s  = cp.word_m;
        next_cp.sleep_m = (r.mode == swp_pkg::SWP_SLEEP);
        next_cp.sleep_s = cp.sleep_m;
    end

    // Frame position registers
    always_ff @(posedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fr <= '{fresh: 1'b1, bit_idx: 3'h0};
        end else begin
            fr <= next_fr;
        end
    end

    // Capture registers
    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cp <= '0;
        end else begin
            cp <= next_cp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status read-back, shifted out on the falling edge
    always_comb begin
        next_ot = ot;
        rd_byte = (cp.cmd == swp_pkg::CMD_STATUS_RDHI)
                ? cp.word_s[15:8] : cp.word_s[7:0];
        next_ot.oe_n = 1'b1;
        next_ot.so   = 1'b0;
        // Sleep answers no reads
        // no reads asleep
        if (!fr.fresh && !cp.sleep_s && cp.byte_cnt != 3'h0 &&
            (cp.cmd == swp_pkg::CMD_STATUS_RDLO ||
             cp.cmd == swp_pkg::CMD_STATUS_RDHI)) begin
            next_ot.oe_n = 1'b0;
            next_ot.so   = rd_byte[3'h7 - fr.bit_idx];
        end
    end

    // Output pin registers
    always_ff @(negedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            ot <= '{so: 1'b0, oe_n: 1'b1};
        end else begin
            ot <= next_ot;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core: frame end detection, command execution, protection
    always_comb begin
        logic        frame_end;
        logic        whole;
        logic        sr_ok;
        logic [20:0] span;
        logic [20:0] a_lo;
        logic [20:0] a_hi;
        logic        is_op;
        logic        blocked;
        frame_end = 1'b0;
        whole     = 1'b0;
        sr_ok     = 1'b0;
        span      = swp_pkg::SPAN_PAGE;
        a_lo      = '0;
        a_hi      = '0;
        is_op     = 1'b0;
        blocked   = 1'b0;
        next_r    = r;
        next_r.cs_m     = cs_n_i;
        next_r.cs_s     = r.cs_m;
        next_r.cs_d     = r.cs_s;
        next_r.wp_m     = wp_n_i;
        next_r.wp_s     = r.wp_m;
        next_r.op_valid = 1'b0;

        // Captured bytes are still while select stays high
        frame_end = r.cs_s && !r.cs_d && (cp.tog != r.seen_tog);
        if (r.cs_s && !r.cs_d) begin
            next_r.seen_tog = cp.tog;
        end
        whole = frame_end && cp.aligned;

        // Internal operation countdown
        // busy while running
        if (r.mode == swp_pkg::SWP_BUSY) begin
            next_r.busy_cnt = r.busy_cnt - BUSY_W'(1);
            if (r.busy_cnt == BUSY_W'(1)) begin
                next_r.mode = swp_pkg::SWP_IDLE;
            end
        end

        // Status write permission from the protect bits and pin
        // software mode
        sr_ok = !r.srp_hi && !(r.srp_lo && !r.wp_s);

        // Address region touched by the command
        case (cp.cmd)
            swp_pkg::CMD_SECTOR_ERS: span = swp_pkg::SPAN_SECTOR;
            swp_pkg::CMD_BLK32_ERS:  span = swp_pkg::SPAN_BLK32;
            swp_pkg::CMD_BLK64_ERS:  span = swp_pkg::SPAN_BLK64;
            default:                 span = swp_pkg::SPAN_PAGE;
        endcase
        a_lo = cp.addr[swp_pkg::ARRAY_AW-1:0] & ~span;
        a_hi = a_lo | span;
        // Protected span sits at one end, so checking both ends suffices
        // range check
        blocked = prot_hit(r.bp, r.cmp, a_lo) ||
                  prot_hit(r.bp, r.cmp, a_hi);

        if (whole) begin
            case (r.mode)
                swp_pkg::SWP_SLEEP: begin
                    if (cp.cmd == swp_pkg::CMD_WAKE) begin
                        next_r.mode = swp_pkg::SWP_IDLE;
                    end
                end
                swp_pkg::SWP_IDLE: begin
                    case (cp.cmd)
                        swp_pkg::CMD_LATCH_SET: begin
                            if (cp.byte_cnt == swp_pkg::LEN_ONE) begin
                                next_r.latch = 1'b1;
                            end
                        end
                        swp_pkg::CMD_LATCH_CLEAR: begin
                            if (cp.byte_cnt == swp_pkg::LEN_ONE) begin
                                next_r.latch = 1'b0;
                            end
                        end
                        swp_pkg::CMD_SLEEP: begin
                            if (cp.byte_cnt == swp_pkg::LEN_ONE) begin
                                next_r.mode = swp_pkg::SWP_SLEEP;
                            end
                        end
                        swp_pkg::CMD_STATUS_WR: begin
                            if (r.latch && sr_ok &&
                                (cp.byte_cnt == swp_pkg::LEN_SR_ONE ||
                                 cp.byte_cnt == swp_pkg::LEN_SR_TWO)) begin
                                next_r.bp = cp.sr_lo[swp_pkg::SB_BP_HI:
                                                     swp_pkg::SB_BP_LO];
                                next_r.srp_lo = cp.sr_lo[swp_pkg::SB_SRP_LO];
                                if (cp.byte_cnt == swp_pkg::LEN_SR_TWO) begin
                                    next_r.srp_hi = cp.sr_hi[
                                        swp_pkg::SB_SRP_HI - swp_pkg::HI_OFS];
                                    next_r.qe = cp.sr_hi[
                                        swp_pkg::SB_QE - swp_pkg::HI_OFS];
                                    next_r.cmp = cp.sr_hi[
                                        swp_pkg::SB_CMP - swp_pkg::HI_OFS];
                                    // Lock bits only ever go to one
                                    next_r.lb = r.lb | cp.sr_hi[
                                        swp_pkg::SB_LB_HI - swp_pkg::HI_OFS:
                                        swp_pkg::SB_LB_LO - swp_pkg::HI_OFS];
                                end
                                next_r.latch    = 1'b0;
                                next_r.mode     = swp_pkg::SWP_BUSY;
                                next_r.busy_cnt = BUSY_W'(OP_BUSY_CYCLES);
                            end
                        end
                        swp_pkg::CMD_PROGRAM,
                        swp_pkg::CMD_PROGRAM_Q: begin
                            is_op = (cp.byte_cnt >= swp_pkg::LEN_PROG);
                            next_r.op_kind = swp_pkg::SWP_OP_PROGRAM;
                        end
                        swp_pkg::CMD_SECTOR_ERS: begin
                            is_op = (cp.byte_cnt == swp_pkg::LEN_ADDR);
                            next_r.op_kind = swp_pkg::SWP_OP_SECTOR;
                        end
                        swp_pkg::CMD_BLK32_ERS,
                        swp_pkg::CMD_BLK64_ERS: begin
                            is_op = (cp.byte_cnt == swp_pkg::LEN_ADDR);
                            next_r.op_kind = swp_pkg::SWP_OP_BLOCK;
                        end
                        swp_pkg::CMD_CHIP_ERS_A,
                        swp_pkg::CMD_CHIP_ERS_B: begin
                            is_op = (cp.byte_cnt == swp_pkg::LEN_ONE);
                            next_r.op_kind = swp_pkg::SWP_OP_CHIP;
                            blocked = prot_any(r.bp, r.cmp);
                            a_lo    = '0;
                        end
                        default: begin
                            is_op = 1'b0;
                        end
                    endcase
                    // Refused commands leave latch and activity alone
                    // needs latch
                    if (is_op && r.latch && !blocked) begin
                        next_r.op_valid = 1'b1;
                        next_r.op_addr  = {cp.addr[23:swp_pkg::ARRAY_AW],
                                           a_lo};
                        next_r.latch    = 1'b0;
                        next_r.mode     = swp_pkg::SWP_BUSY;
                        next_r.busy_cnt = BUSY_W'(OP_BUSY_CYCLES);
                    end
                end
                default: begin
                    next_r.mode = r.mode;
                end
            endcase
        end

        // Status word assembled from the next state
        // upper byte layout
        next_r.word = '0;
        next_r.word[swp_pkg::SB_BUSY] =
            (next_r.mode == swp_pkg::SWP_BUSY);
        next_r.word[swp_pkg::SB_LATCH] = next_r.latch;
        next_r.word[swp_pkg::SB_BP_HI:swp_pkg::SB_BP_LO] = next_r.bp;
        next_r.word[swp_pkg::SB_SRP_LO] = next_r.srp_lo;
        next_r.word[swp_pkg::SB_SRP_HI] = next_r.srp_hi;
        next_r.word[swp_pkg::SB_QE]     = next_r.qe;
        next_r.word[swp_pkg::SB_LB_HI:swp_pkg::SB_LB_LO] = next_r.lb;
        next_r.word[swp_pkg::SB_CMP]    = next_r.cmp;
    end

    // Core registers; power-up clears latch and the lock code
    // power-up clear
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, wp_m: 1'b1,
                   wp_s: 1'b1, mode: swp_pkg::SWP_IDLE,
                   op_kind: swp_pkg::SWP_OP_PROGRAM, default: '0};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from registers
    assign so_o             = ot.so;
    assign so_oe_n_o        = ot.oe_n;
    assign status_word_o    = r.word;
    assign array_op_valid_o = r.op_valid;
    assign array_op_kind_o  = r.op_kind;
    assign array_op_addr_o  = r.op_addr;

endmodule

/* tb/swp_core_asserts.sv */
module swp_core_asserts #(
    parameter int OP_BUSY_CYCLES = 64
) (
    // Clock and reset
    input wire logic             ref_clk_i,
    input wire logic             nrst_i,
    // Link pins
    input wire logic             cs_n_i,
    input wire logic             wp_n_i,
    // Status and array requests
    input wire logic [15:0]      status_word_o,
    input wire logic             array_op_valid_o,
    input wire swp_pkg::swp_op_e array_op_kind_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire [15:0] s = status_word_o;
    // No area protected under either polarity
    wire none = s[14] ? s[4:3] == 2'h3 : s[4:2] == 3'h0;
    // Busy cycles counted, since a repetition cannot take the parameter
    logic [7:0] busy_len;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_len <= 8'h0;
        end else begin
            busy_len <= s[0] ? busy_len + 8'h1 : 8'h0;
        end
    end
    // Busy stands at least three cycles, then drops within eight more
    sequence busy_run;
        s[0] [*3] ##[1:8] !s[0];
    endsequence
    AST_OP_LATCH: assert property (
        array_op_valid_o |-> $past(s[1])) else $error("op without latch");
    AST_OP_CLEAR: assert property (
        array_op_valid_o |-> ##[0:1] (s[0] && !s[1])) else $error("no clear");
    AST_BUSY_LEN: assert property (
        $rose(s[0]) |-> busy_run) else $error("busy length wrong");
    AST_BUSY_CNT: assert property (
        $fell(s[0]) |-> busy_len == OP_BUSY_CYCLES)
        else $error("busy count wrong");
    AST_BUSY_SRC: assert property (
        $rose(s[0]) |-> $past(s[1])) else $error("busy without latch");
    AST_CHIP_NONE: assert property (
        array_op_valid_o && array_op_kind_o == swp_pkg::SWP_OP_CHIP |-> none)
        else $error("chip erase while protected");
    AST_FRAME_ONLY: assert property (
        $changed(s[14:2]) |-> $past(cs_n_i, 2)) else $error("stray change");
    AST_PIN_LOCK: assert property (
        (s[8:7] == 2'h1 && !wp_n_i) [*6] |=> $stable(s[14:2]))
        else $error("pin lock broken");
    AST_LOCKDOWN: assert property (
        s[8] |=> $stable(s[14:2])) else $error("lockdown broken");
endmodule

/* tb/swp_host.sv */
module swp_host (
    // Serial link toward the device
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle link: clock parked low, select high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic xfer(input logic [39:0] d, input int n,
                        output logic [7:0] r);
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #13.3 si_o = d[i];
            #18.7 sclk_o = 1'b1;
            r = {r[6:0], so_i};
            #32 sclk_o = 1'b0;
        end
        #13.3 cs_n_o = 1'b1;
        // Released line must not keep the last bit
        si_o = ~si_o;
        #50.7;
    endtask
endmodule

/* tb/serial_flash_write_protection_bench.sv */
module serial_flash_write_protection_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i, nrst_i, wp_n_i, sclk, cs_n, si, so, op, got_op;
    logic [15:0] sw;
    logic [7:0]  rd;
    logic        oen;
    logic [1:0]  kind, got_kind;
    logic [23:0] addr, got_addr;
    int          bad_count, checks;
    swp_core #(.OP_BUSY_CYCLES(4)) dut (.ref_clk_i, .nrst_i, .sclk_i(sclk),
        .cs_n_i(cs_n), .si_i(si), .wp_n_i, .so_o(so), .so_oe_n_o(oen),
        .status_word_o(sw), .array_op_valid_o(op), .array_op_kind_o(kind),
        .array_op_addr_o(addr));
    swp_host host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Catch any accepted array request
    always @(posedge ref_clk_i) begin
        if (op === 1'b1) begin
            got_op <= 1'b1;
            got_kind <= kind;
            got_addr <= addr;
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Latch set, then the frame, then let busy drain
    task automatic wr(input logic [39:0] d, input int n);
        host.xfer(40'h06, 8, rd);
        got_op = 1'b0;
        host.xfer(d, n, rd);
        for (int i = 0; i < 50 && sw[0] !== 1'b0; i++) @(posedge ref_clk_i);
    endtask
    task automatic rst();
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Size from level code; top or bottom; polarity flips it
    function automatic logic prot(logic [4:0] b, logic v, logic [20:0] a);
        logic [21:0] z;
        logic        h;
        z = 22'h1 << ((b[4] ? 11 : 15) + (b[4] && b[2:0] == 3'h5 ? 4 : b[2:0]));
        h = b[3] ? {1'b0, a} < z : {1'b0, a} >= 22'h200000 - z;
        if (b[2:0] == 3'h0) h = 1'b0;
        if (b[2:1] == 2'h3) h = 1'b1;
        return h ^ v;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0]  bp;
        logic        v;
        logic [20:0] a;
        logic [15:0] e;
        bad_count = 0;
        checks = 0;
        got_op = 1'b0;
        nrst_i = 1'b0;
        wp_n_i = 1'b1;
        void'($urandom(66));
        rst();
        host.xfer(40'h0500, 16, rd);
        chk({8'h0, rd}, 16'h0);
        chk({23'h0, oen}, 24'h1);
        chk(sw, 16'h0);
        host.xfer(40'h06, 8, rd);
        chk(sw, 16'h2);
        host.xfer(40'h04, 8, rd);
        host.xfer(40'h011C, 16, rd);
        chk(sw, 16'h0);
        host.xfer(40'hB9, 8, rd);
        host.xfer(40'h06, 8, rd);
        chk(sw, 16'h0);
        host.xfer(40'hAB, 8, rd);
        $display("test latch done");
        // Random codes and targets, 4K corners among them
        for (int i = 0; i < 24; i++) begin
            bp = 5'($urandom);
            v = 1'($urandom);
            a = i % 3 == 0 ? 21'h1FF000 : i % 3 == 1 ? 21'hFFF : 21'($urandom);
            @(posedge ref_clk_i) wp_n_i <= 1'($urandom);
            wr({8'h01, 1'b0, bp, 2'h0, 1'b0, v, 6'h0}, 24);
            e = {1'b0, v, 6'h0, 1'b0, bp, 2'h0};
            chk(sw, e);
            host.xfer(40'h3500, 16, rd);
            chk({8'h0, rd}, {8'h0, e[15:8]});
            wr({8'h20, 3'h0, a}, 32);
            chk({15'h0, got_op}, {15'h0, !prot(bp, v, a)});
            chk(sw, e | {14'h0, prot(bp, v, a), 1'b0});
            if (!prot(bp, v, a)) begin
                chk({22'h0, got_kind}, 24'h1);
                chk(got_addr, {3'h0, a[20:12], 12'h0});
            end
            wr(40'hC7, 8);
            chk({15'h0, got_op},
                {15'h0, v ? bp[2:1] == 2'h3 : bp[2:0] == 3'h0});
        end
        $display("test protection done");
        // Lock codes 1 to 3, pin low then high, then a power cycle
        for (int c = 1; c < 4; c++) begin
            e = {7'h0, 2'(c), 7'h0};
            wr({8'h01, c[0], 14'h0, c[1]}, 24);
            @(posedge ref_clk_i) wp_n_i <= 1'b0;
            wr(40'h010000, 24);
            chk(sw & 16'hFFFD, e);
            @(posedge ref_clk_i) wp_n_i <= 1'b1;
            wr(40'h010000, 24);
            chk(sw & 16'hFFFD, c == 1 ? 16'h0 : e);
            rst();
            chk(sw, 16'h0);
        end
        $display("test lock done");
        complete_run();
    end
    initial begin
        #400us;
        bad_count++;
        complete_run();
    end
endmodule
bind swp_core swp_core_asserts #(.OP_BUSY_CYCLES(OP_BUSY_CYCLES)) u_chk (
    .ref_clk_i, .nrst_i, .cs_n_i, .wp_n_i, .status_word_o,
    .array_op_valid_o, .array_op_kind_o);
